// ===== design/sbst_pkg.sv
// Shared constants for the sample buffer status and trigger gating block.
// Assumes a single system clock domain and an active-low synchronous reset.
package sbst_pkg;
	localparam int SBST_SAMPLE_W = 16;
	localparam int SBST_DEPTH = 32;
	localparam int SBST_PTR_W = 5;
	localparam int SBST_CNT_W = 6;
	localparam int SBST_IN_FIFO_DEPTH = 4;
	localparam logic [5:0] SBST_CNT_FULL = 6'h20;
	localparam logic [7:0] SBST_OFS_STATUS = 8'h00;
	localparam logic [7:0] SBST_OFS_TRIG_CFG = 8'h0A;
	localparam logic [7:0] SBST_RST_STATUS = 8'h00;
	localparam logic [7:0] SBST_RST_TRIG_CFG = 8'h00;
	localparam int SBST_BIT_OVF = 7;
	localparam int SBST_BIT_WMRK = 6;
	localparam int SBST_CNT_MSB = 5;
	localparam int SBST_TRIG_LSB = 1;
	localparam int SBST_TRIG_MSB = 5;
	localparam logic [1:0] SBST_MODE_OFF = 2'h0;
	localparam logic [1:0] SBST_MODE_CIRC = 2'h1;
	localparam logic [1:0] SBST_MODE_FILL = 2'h2;
	localparam logic [1:0] SBST_MODE_TRIG = 2'h3;
	typedef enum logic [2:0] {
		SBST_ST_OFF = 3'b001,
		SBST_ST_RUN = 3'b010,
		SBST_ST_GATED = 3'b100
	} sbst_state_t;
endpackage

// ===== design/sbst_fifo.sv
// Small input FIFO with valid/ready on both sides.
// Assumes both sides run on the system clock.
module sbst_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Filling side.
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Draining side.
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out = mem_reg[rp_reg];

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_reg[wp_reg] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			in_ready_out <= 1'b1;
		end else begin
			if (push) begin
				wp_reg <= AW'(wp_reg + 1'b1);
			end
			if (pop) begin
				rp_reg <= AW'(rp_reg + 1'b1);
			end
			if (push && !pop) begin
				cnt_reg <= (AW+1)'(cnt_reg + 1'b1);
				in_ready_out <= (cnt_reg != (AW+1)'(DEPTH - 1));
			end else if (pop && !push) begin
				cnt_reg <= (AW+1)'(cnt_reg - 1'b1);
				in_ready_out <= 1'b1;
			end
		end
	end
endmodule

// ===== design/sbst_mem.sv
// Sample store memory, one write port and one registered read port.
// Assumes the controller keeps addresses in range.
module sbst_mem
	import sbst_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Write port.
	input wire logic wr_en_in,
	input wire logic [SBST_PTR_W-1:0] wr_addr_in,
	input wire logic [SBST_SAMPLE_W-1:0] wr_data_in,
	// Read port.
	input wire logic rd_en_in,
	input wire logic [SBST_PTR_W-1:0] rd_addr_in,
	output logic [SBST_SAMPLE_W-1:0] rd_data_out
);
	logic [SBST_SAMPLE_W-1:0] mem_reg [SBST_DEPTH];

	always_ff @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rd_data_out <= '0;
		end else if (rd_en_in) begin
			rd_data_out <= mem_reg[rd_addr_in];
		end
	end
endmodule

// ===== design/sbst_top.sv
// Status, count and trigger gating logic of a 32-entry sample buffer.
// Assumes register requests and detector flags come from logic on clk_sys_in.
// Assumes buf_mode_in is steady through reset, since any change of it flushes the store.
// What this block does
// R1: With buffer enabled, status address reads overflow, watermark and count.
// R2: Status address shows data-ready status when mode is zero, else buffer status.
// R3: Overflow flag set on overflow, held while overflowed, zero otherwise.
// R4: Watermark flag high while count is at or above a nonzero watermark.
// R5: In trigger mode the watermark flag shows a trigger was detected.
// R6: Reading buffer status clears the buffer interrupt source bit.
// R7: The buffer interrupt source bit sets again on the next stored sample.
// R8: Six-bit count gives stored samples, zero empty, up to 32.
// R9: In trigger mode an enabled event gates the buffer, keeping prior samples.
// R10: Trigger config bit 5 enables transient, bit 4 orientation gating.
// R11: Bits 3, 2, 1 enable pulse, free-fall/motion, vector-magnitude gating.
// R12: While gated, no samples are stored and only pops lower the count, until emptied or reconfigured.
module sbst_top
	import sbst_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Register port.
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// Buffer setup and external status.
	input wire logic [1:0] buf_mode_in,
	input wire logic [5:0] wmrk_level_in,
	input wire logic [7:0] sample_ready_status_in,
	// Detector interrupt flags, bit 5 transient down to bit 1 vector magnitude.
	input wire logic [7:0] event_flags_in,
	// Incoming samples.
	input wire logic sample_valid_in,
	input wire logic [SBST_SAMPLE_W-1:0] sample_data_in,
	output logic sample_ready_out,
	// Sample readout.
	input wire logic pop_in,
	output logic [SBST_SAMPLE_W-1:0] pop_data_out,
	// Status outputs.
	output logic src_fifo_out,
	output logic gated_out
);
	sbst_state_t state_reg;
	sbst_state_t state_next;
	logic [7:0] trig_cfg_reg;
	logic [1:0] mode_prev_reg;
	logic [SBST_CNT_W-1:0] cnt_reg;
	logic [SBST_PTR_W-1:0] wp_reg;
	logic [SBST_PTR_W-1:0] rp_reg;
	logic ovf_reg;
	logic trig_hit_reg;
	logic q_valid;
	logic [SBST_SAMPLE_W-1:0] q_data;
	logic q_take;
	logic full;
	logic reconfig;
	logic wr_eff;
	logic ovf_evt;
	logic pop_eff;
	logic trig_fire;
	logic stat_rd;
	logic wm_flag;
	logic [7:0] buf_status;

	// Four-word queue between the sample source and the store; it drains while no pop is asked.
	sbst_fifo #(
		.WIDTH(SBST_SAMPLE_W),
		.DEPTH(SBST_IN_FIFO_DEPTH)
	) u_in_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(sample_valid_in),
		.in_data_in(sample_data_in),
		.in_ready_out(sample_ready_out),
		.out_valid_out(q_valid),
		.out_data_out(q_data),
		.out_ready_in(!pop_in)
	);

	// The store keeps up to 32 samples; its read data stand in a register until the next pop.
	sbst_mem u_store (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(wr_eff),
		.wr_addr_in(wp_reg),
		.wr_data_in(q_data),
		.rd_en_in(pop_eff),
		.rd_addr_in(rp_reg),
		.rd_data_out(pop_data_out)
	);

	// A host pop stalls the input queue for that cycle, so the queue can fill.
	assign q_take = q_valid && !pop_in;
	assign full = (cnt_reg == SBST_CNT_FULL);
	assign reconfig = (buf_mode_in != mode_prev_reg);
	// Fill mode stops storing at 32; circular and trigger modes overwrite the oldest.
	assign wr_eff = q_take && (state_reg == SBST_ST_RUN) && !reconfig
		&& !(full && buf_mode_in == SBST_MODE_FILL);
	assign ovf_evt = q_take && (state_reg == SBST_ST_RUN) && !reconfig && full; // R3
	// Pops on an empty store, in off mode or in a mode-change cycle are ignored.
	assign pop_eff = pop_in && (cnt_reg != '0) && (state_reg != SBST_ST_OFF) && !reconfig;
	// Only enabled detector flags in bits 5 to 1 can gate the store.
	assign trig_fire = (state_reg == SBST_ST_RUN) && (buf_mode_in == SBST_MODE_TRIG) && !reconfig
		&& |(event_flags_in[SBST_TRIG_MSB:SBST_TRIG_LSB]
		& trig_cfg_reg[SBST_TRIG_MSB:SBST_TRIG_LSB]); // R9 R10 R11
	// Only a read of the buffer view clears the interrupt source.
	assign stat_rd = reg_rd_in && (reg_addr_in == SBST_OFS_STATUS) && (buf_mode_in != SBST_MODE_OFF);
	assign wm_flag = (buf_mode_in == SBST_MODE_TRIG) ? trig_hit_reg : // R5
		((wmrk_level_in != '0) && (cnt_reg >= wmrk_level_in)); // R4
	assign buf_status = {ovf_reg, wm_flag, cnt_reg}; // R1 R8

	// The gated state holds the store until the host empties it or the mode changes.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SBST_ST_OFF: begin
				if (buf_mode_in != SBST_MODE_OFF) begin
					state_next = SBST_ST_RUN;
				end
			end
			SBST_ST_RUN: begin
				if (buf_mode_in == SBST_MODE_OFF) begin
					state_next = SBST_ST_OFF;
				end else if (trig_fire) begin
					state_next = SBST_ST_GATED; // R9
				end
			end
			SBST_ST_GATED: begin
				if (reconfig) begin
					state_next = (buf_mode_in == SBST_MODE_OFF) ? SBST_ST_OFF : SBST_ST_RUN; // R12
				end else if (cnt_reg == '0) begin
					state_next = SBST_ST_RUN; // R12
				end
			end
			default: begin
				state_next = SBST_ST_OFF;
			end
		endcase
	end

	// State, mode history and the gated output move together on each edge.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_reg <= SBST_ST_OFF;
			mode_prev_reg <= SBST_MODE_OFF;
			gated_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			mode_prev_reg <= buf_mode_in;
			gated_out <= (state_next == SBST_ST_GATED);
		end
	end

	// Only the trigger configuration is writable; bits 7, 6 and 0 are kept but gate nothing.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			trig_cfg_reg <= SBST_RST_TRIG_CFG; // R10 R11
		end else if (reg_wr_in && reg_addr_in == SBST_OFS_TRIG_CFG) begin
			trig_cfg_reg <= reg_wdata_in;
		end
	end

	// A change of buffer mode flushes the store.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_reg <= SBST_RST_STATUS[SBST_CNT_MSB:0];
			wp_reg <= '0;
			rp_reg <= '0;
		end else if (reconfig) begin
			cnt_reg <= '0;
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (wr_eff) begin
				wp_reg <= SBST_PTR_W'(wp_reg + 1'b1);
			end
			if (pop_eff || (wr_eff && full)) begin
				rp_reg <= SBST_PTR_W'(rp_reg + 1'b1);
			end
			if (wr_eff && !full) begin
				cnt_reg <= SBST_CNT_W'(cnt_reg + 1'b1); // R8
			end else if (pop_eff) begin
				cnt_reg <= SBST_CNT_W'(cnt_reg - 1'b1); // R8
			end
		end
	end

	// Overflow stays set until a pop makes room or the mode changes.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ovf_reg <= SBST_RST_STATUS[SBST_BIT_OVF];
		end else begin
			ovf_reg <= ovf_evt || (ovf_reg && !pop_eff && !reconfig); // R3
		end
	end

	// The trigger flag lasts until the gated store has been emptied or the mode changes.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			trig_hit_reg <= SBST_RST_STATUS[SBST_BIT_WMRK];
		end else begin
			trig_hit_reg <= trig_fire || (trig_hit_reg && !reconfig
				&& !(state_reg == SBST_ST_GATED && cnt_reg == '0)); // R5
		end
	end

	// A sample stored in the same cycle as a status read keeps the bit set.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			src_fifo_out <= 1'b0;
		end else begin
			src_fifo_out <= wr_eff || (src_fifo_out && !stat_rd); // R6 R7
		end
	end

	// Read data stand until the next read; unmapped addresses read as zero.
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == SBST_OFS_STATUS) begin
				reg_rdata_out <= (buf_mode_in == SBST_MODE_OFF) ? sample_ready_status_in : buf_status; // R1 R2
			end else if (reg_addr_in == SBST_OFS_TRIG_CFG) begin
				reg_rdata_out <= trig_cfg_reg;
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	// Checks below run on the system clock and rest while reset is held.
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	// Register view, flag and interrupt source checks.
	status_read_a: assert property (stat_rd |=> reg_rdata_out == $past(buf_status)) // R1
		else $error("Status read did not return buffer status.");
	alias_mode_a: assert property (reg_rd_in && reg_addr_in == SBST_OFS_STATUS && buf_mode_in == SBST_MODE_OFF // R2
		|=> reg_rdata_out == $past(sample_ready_status_in))
		else $error("Status alias did not return data-ready status.");
	ovf_flag_a: assert property (ovf_evt |=> ovf_reg ##0 (ovf_reg && full) [*1]) // R3
		else $error("Overflow flag not held after overflow.");
	ovf_clear_a: assert property (ovf_reg && !full |-> 1'b0) // R3
		else $error("Overflow flag high while buffer not full.");
	wmrk_flag_a: assert property (buf_mode_in != SBST_MODE_TRIG && wmrk_level_in != '0 // R4
		&& cnt_reg >= wmrk_level_in |-> buf_status[SBST_BIT_WMRK])
		else $error("Watermark flag low at or above level.");
	trig_flag_a: assert property (trig_fire ##1 buf_mode_in == SBST_MODE_TRIG |-> buf_status[SBST_BIT_WMRK]) // R5
		else $error("Trigger flag not shown after trigger.");
	src_clear_a: assert property (stat_rd && !wr_eff |=> !src_fifo_out) // R6
		else $error("Status read did not clear interrupt source.");
	src_set_a: assert property (wr_eff |=> src_fifo_out) // R7
		else $error("Stored sample did not set interrupt source.");
	count_range_a: assert property (cnt_reg <= SBST_CNT_FULL) // R8
		else $error("Sample count above 32.");
	gate_event_a: assert property (trig_fire |=> gated_out && !wr_eff) // R9
		else $error("Trigger did not gate the buffer.");
	gate_mask_a: assert property (trig_fire |-> |(event_flags_in[5:1] & trig_cfg_reg[5:1])) // R10 R11
		else $error("Disabled event gated the buffer.");
	gated_hold_a: assert property (state_reg == SBST_ST_GATED && !pop_eff && !reconfig // R12
		|=> $stable(cnt_reg) && $stable(wp_reg))
		else $error("Gated buffer changed without a pop.");

	// Count, flag and gating bookkeeping around stores, pops and mode changes.
	cnt_store_a: assert property (wr_eff && !full |=> cnt_reg == SBST_CNT_W'($past(cnt_reg) + 1'b1)) // R8
		else $error("Stored sample did not raise the count.");
	pop_count_a: assert property (pop_eff |=> cnt_reg == SBST_CNT_W'($past(cnt_reg) - 1'b1)) // R8
		else $error("Pop did not lower the count.");
	off_empty_a: assert property (state_reg == SBST_ST_OFF |-> cnt_reg == '0) // R8
		else $error("Store not empty while buffer is off.");
	fill_stop_a: assert property (buf_mode_in == SBST_MODE_FILL && full |-> !wr_eff) // R8
		else $error("Fill mode stored past 32 samples.");
	wm_clear_a: assert property (buf_mode_in != SBST_MODE_TRIG && cnt_reg < wmrk_level_in // R4
		|-> !buf_status[SBST_BIT_WMRK])
		else $error("Watermark flag high below level.");
	src_hold_a: assert property (src_fifo_out && !stat_rd |=> src_fifo_out) // R6
		else $error("Interrupt source dropped without a status read.");
	gate_store_a: assert property (gated_out |-> !wr_eff) // R9
		else $error("Gated buffer stored a sample.");
	trig_mode_a: assert property (buf_mode_in != SBST_MODE_TRIG |-> !trig_fire) // R9
		else $error("Trigger outside trigger mode.");
	cfg_write_a: assert property (reg_wr_in && reg_addr_in == SBST_OFS_TRIG_CFG // R10 R11
		|=> trig_cfg_reg == $past(reg_wdata_in))
		else $error("Trigger configuration write lost.");
	rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) // R1
		else $error("Read data changed without a read.");
	mode_flush_a: assert property (reconfig |=> cnt_reg == '0 && !ovf_reg && !trig_hit_reg) // R12
		else $error("Mode change did not flush the store.");
	ungate_empty_a: assert property (gated_out && cnt_reg == '0 |=> !gated_out) // R12
		else $error("Buffer stayed gated once empty.");
	ungate_mode_a: assert property (gated_out && reconfig |=> !gated_out) // R12
		else $error("Buffer stayed gated after a mode change.");

	// Main scenarios: trigger, overflow, status clear, queue full and fill stop.
	trig_seen_c: cover property (trig_fire ##1 gated_out);
	overflow_c: cover property (ovf_evt);
	status_clear_c: cover property (src_fifo_out && stat_rd);
	queue_full_c: cover property (sample_valid_in && !sample_ready_out);
	fill_stop_c: cover property (ovf_evt && buf_mode_in == SBST_MODE_FILL);
endmodule

// ===== verif/sbst_host.sv
// Host processor model that reaches the block's registers and readout.
// Assumes the bench clock and calls its tasks from one process at a time.
module sbst_host (
	// Clock.
	input wire logic clk_sys_in,
	// Register port.
	output logic [7:0] reg_addr_out,
	output logic reg_rd_out,
	output logic reg_wr_out,
	output logic [7:0] reg_wdata_out,
	input wire logic [7:0] reg_rdata_in,
	// Readout.
	output logic pop_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr_out = 8'h00;
		reg_rd_out = 1'b0;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		pop_out = 1'b0;
	end
	// Read data stand from the edge that takes the strobe; an idle edge keeps two reads apart.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(posedge clk_sys_in);
		#2;
		reg_rd_out = 1'b0;
		d = reg_rdata_in;
		@(posedge clk_sys_in);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr_out = a;
		reg_wdata_out = v;
		reg_wr_out = 1'b1;
		@(posedge clk_sys_in);
		#2;
		reg_wr_out = 1'b0;
	endtask
	task automatic pop();
		pop_out = 1'b1;
		@(posedge clk_sys_in);
		#2;
		pop_out = 1'b0;
	endtask
	// Holds the pop strobe for n edges, which stalls the input queue all that time.
	task automatic pops(input int n);
		pop_out = 1'b1;
		repeat (n) begin
			@(posedge clk_sys_in);
			#2;
		end
		pop_out = 1'b0;
	endtask
endmodule

// ===== verif/test_sample_buffer_status_trigger.sv
// Self-checking bench for the sample buffer status and trigger block.
// Assumes the host model drives the register port and readout strobe.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module test_sample_buffer_status_trigger;
	timeunit 1ns;
	timeprecision 1ns;
	import sbst_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_out, event_flags_in = 8'h00;
	logic reg_rd, reg_wr, pop, sample_ready_out, src_fifo_out, gated_out;
	logic [1:0] buf_mode_in = 2'h0;
	logic [5:0] wmrk_level_in = 6'h00;
	logic [7:0] sample_ready_status_in = 8'h5A;
	logic sample_valid_in = 1'b0;
	logic [15:0] sample_data_in = 16'h0000, pop_data_out;
	int num_errors = 0;
	int n_tests = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	sbst_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr), .reg_rd_in(reg_rd),
		.reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata_out), .buf_mode_in(buf_mode_in),
		.wmrk_level_in(wmrk_level_in), .sample_ready_status_in(sample_ready_status_in), .event_flags_in(event_flags_in),
		.sample_valid_in(sample_valid_in), .sample_data_in(sample_data_in), .sample_ready_out(sample_ready_out),
		.pop_in(pop), .pop_data_out(pop_data_out), .src_fifo_out(src_fifo_out), .gated_out(gated_out));
	sbst_host host (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr), .reg_rd_out(reg_rd), .reg_wr_out(reg_wr),
		.reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata_out), .pop_out(pop));
	task automatic close_out();
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			#2;
		end
	endtask
	// Leaves valid high so back-to-back pushes never toggle it in one step.
	task automatic push(input logic [15:0] d);
		int i;
		i = 0;
		sample_data_in = d;
		sample_valid_in = 1'b1;
		while (sample_ready_out !== 1'b1 && i < 20) begin
			step(1);
			i++;
		end
		if (i == 20) begin
			num_errors++;
			close_out();
		end else begin
			step(1);
		end
	endtask
	task automatic settle(input int n);
		sample_valid_in = 1'b0;
		step(n);
	endtask
	task automatic status(input logic [7:0] e);
		logic [7:0] d;
		host.rd(SBST_OFS_STATUS, d);
		`CHK("status", e, d)
	endtask
	task automatic new_mode(input logic [1:0] m);
		buf_mode_in = 2'h0;
		step(2);
		buf_mode_in = m;
		step(2);
	endtask
	task automatic t_reset();
		logic [7:0] d;
		`CHK("src", 1'b0, src_fifo_out)
		`CHK("gated", 1'b0, gated_out)
		status(8'h5A);
		sample_ready_status_in = 8'hA5;
		status(8'hA5);
		host.rd(SBST_OFS_TRIG_CFG, d);
		`CHK("cfg", 8'h00, d)
		host.rd(8'h05, d);
		`CHK("unmapped", 8'h00, d)
	endtask
	task automatic t_count();
		new_mode(SBST_MODE_CIRC);
		wmrk_level_in = 6'h03;
		push(16'h1001);
		push(16'h1002);
		settle(4);
		status(8'h02);
		`CHK("src", 1'b0, src_fifo_out)
		push(16'h1003);
		settle(4);
		`CHK("src", 1'b1, src_fifo_out)
		status(8'h43);
		host.pop();
		`CHK("pop", 16'h1001, pop_data_out)
		status(8'h02);
	endtask
	// Circular mode overwrites the oldest sample; fill mode drops the newest.
	task automatic t_overflow();
		for (int k = 0; k < 2; k++) begin
			new_mode((k == 0) ? SBST_MODE_CIRC : SBST_MODE_FILL);
			wmrk_level_in = 6'h00;
			for (int i = 0; i < 33; i++)
				push(16'h2000 + 16'(i));
			settle(8);
			status(8'hA0);
			host.pop();
			`CHK("pop", (k == 0) ? 16'h2001 : 16'h2000, pop_data_out)
			status(8'h1F);
			sample_data_in = 16'h2100;
			sample_valid_in = 1'b1;
			host.pops(6);
			`CHK("ready", 1'b0, sample_ready_out)
			`CHK("pop", (k == 0) ? 16'h2007 : 16'h2006, pop_data_out)
			settle(8);
			status(8'h1D);
		end
	endtask
	task automatic t_trigger();
		logic [7:0] d;
		for (int b = 1; b < 6; b++) begin
			new_mode(SBST_MODE_CIRC);
			host.wr(SBST_OFS_TRIG_CFG, 8'h01 << b);
			host.rd(SBST_OFS_TRIG_CFG, d);
			`CHK("cfg", 8'h01 << b, d)
			new_mode(SBST_MODE_TRIG);
			push(16'h3000);
			push(16'h3001);
			settle(4);
			event_flags_in = 8'h3E & ~(8'h01 << b);
			step(2);
			`CHK("gated", 1'b0, gated_out)
			event_flags_in = 8'h01 << b;
			step(1);
			event_flags_in = 8'h00;
			step(1);
			`CHK("gated", 1'b1, gated_out)
			status(8'h42);
			push(16'h3002);
			settle(4);
			status(8'h42);
			host.pop();
			`CHK("pop", 16'h3000, pop_data_out)
		end
	endtask
	initial begin
		step(5);
		rst_n_in = 1'b1;
		t_reset();
		t_count();
		t_overflow();
		t_trigger();
		close_out();
	end
	initial begin
		#1000000;
		num_errors++;
		close_out();
	end
endmodule
